// File: core/pmic_regs_pkg.sv
// Package: register map, field positions, reset values and timing constants of the regulator bank
package pmic_regs_pkg;
   // Register offsets
   localparam logic [7:0] OFF_TOP_EVENT_FLAGS = 8'h02;
   localparam logic [7:0] OFF_TOP_EVENT_MASK = 8'h03;
   localparam logic [7:0] OFF_TOP_LIVE_STATUS = 8'h04;
   localparam logic [7:0] OFF_SEL_PIN1_CODE = 8'h06;
   localparam logic [7:0] OFF_SEL_PIN2_CODE = 8'h07;
   localparam logic [7:0] OFF_BIAS_INPUT_CONFIG = 8'h08;
   localparam logic [7:0] OFF_PROTECTION_CONFIG = 8'h09;
   localparam logic [7:0] OFF_OUTPUT_ENABLE_CONTROL = 8'h0b;
   localparam logic [7:0] OFF_GLOBAL_RAMP_CONFIG = 8'h11;
   localparam logic [7:0] OFF_OUTPUT_EVENT_FLAGS = 8'h20;
   localparam logic [7:0] OFF_OUTPUT_EVENT_MASK = 8'h21;
   localparam logic [7:0] OFF_OUTPUT_LIVE_STATUS = 8'h22;
   localparam logic [7:0] OFF_OUTPUT1_VOLTAGE_CODE = 8'h23;
   localparam logic [7:0] OFF_OUTPUT1_RANGE_CONFIG = 8'h25;

   // Top-level event bit positions
   localparam int BIT_EXT_REF = 5;
   localparam int BIT_BIAS_SWO = 4;
   localparam int BIT_UNDERVOLTAGE = 3;
   localparam int BIT_THERMAL_SHUTDOWN = 2;
   localparam int BIT_WARN_HIGH = 1;
   localparam int BIT_WARN_LOW = 0;

   // Per-output event positions: power-good in bits 1:0, short in bits 5:4
   localparam int BIT_POWER_GOOD_LO = 0;
   localparam int BIT_SHORT_LO = 4;

   // Reset values
   localparam logic [5:0] TOP_MASK_RST = 6'h37;
   localparam logic [3:0] OUT_MASK_RST = 4'hf;
   localparam logic [2:0] SOFT_STOP_RST = 3'h0;
   localparam logic [2:0] SOFT_START_RST = 3'h4;
   localparam logic [7:0] VOLTAGE_CODE_RST = 8'h41;
   localparam logic [7:0] RANGE_CONFIG_RST = 8'h84;
   localparam logic [12:0] TARGET_MV_RST = 13'h0ce4;

   // Output voltage decode: saturation code shared by the low and mid ranges, and one for the high range
   localparam logic [7:0] SAT_CODE_LOW_MID = 8'h8c;
   localparam logic [7:0] SAT_CODE_HIGH = 8'ha0;

   // Power-good fault time-outs in milliseconds, clock rate in MHz
   localparam int MCLK_MHZ = 50;
   localparam int POK_TO1_MS = 25;
   localparam int POK_TO2_MS = 50;
   localparam int POK_TO3_MS = 100;
   localparam int STRAP_SETTLE_CYC = 3;
endpackage : pmic_regs_pkg

// File: core/level_sync.sv
// Two flip-flop synchroniser for a vector of independent levels
module level_sync #(
   parameter int WIDTH = 1
) (
   // Destination clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("level_sync: WIDTH must be at least 1");
      end
   endgenerate

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : level_sync

// File: core/pmic_regs.sv
// Control and status register bank of a dual-output step-down regulator
module pmic_regs #(
   parameter int POK_TO1_CYC = pmic_regs_pkg::POK_TO1_MS * 1000 * pmic_regs_pkg::MCLK_MHZ,
   parameter int POK_TO2_CYC = pmic_regs_pkg::POK_TO2_MS * 1000 * pmic_regs_pkg::MCLK_MHZ,
   parameter int POK_TO3_CYC = pmic_regs_pkg::POK_TO3_MS * 1000 * pmic_regs_pkg::MCLK_MHZ
) (
   // Core clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Register access port on the serial link clock
   input wire logic link_clk,
   input wire logic acc_valid,
   input wire logic acc_write,
   input wire logic [7:0] acc_addr,
   input wire logic [7:0] acc_wdata,
   output logic acc_busy,
   output logic acc_done,
   output logic [7:0] acc_rdata,
   // Analog comparator levels
   input wire logic main_supply_input_low,
   input wire logic temp_above_165,
   input wire logic temp_above_140,
   input wire logic temp_above_120,
   input wire logic external_reference_valid,
   input wire logic alternate_bias_input_good,
   input wire logic [1:0] output_below_short,
   input wire logic [1:0] output_above_power_good,
   // Enable pins and select straps
   input wire logic [1:0] output_enable_pin,
   input wire logic [4:0] select_pin1,
   input wire logic [4:0] select_pin2,
   // Controls to the power stage and interrupt request
   output logic [1:0] output_enable,
   output logic bias_from_alternate,
   output logic [2:0] soft_start_ramp_code,
   output logic [2:0] soft_stop_ramp_code,
   output logic [12:0] output1_target_mv,
   output logic irq_req
);
   localparam int CNT_W = 24;

   generate
      if (POK_TO1_CYC < 1 || POK_TO2_CYC < 1 || POK_TO3_CYC < 1 ||
          POK_TO1_CYC >= (1 << CNT_W) || POK_TO2_CYC >= (1 << CNT_W) ||
          POK_TO3_CYC >= (1 << CNT_W)) begin : g_bad_timeout
         $error("pmic_regs: power-good time-out out of counter range");
      end
   endgenerate

   // True when an access hits the given offset
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
      addr_hit = (a == off);
   endfunction : addr_hit

   // Target voltage in millivolts from range and code
   function automatic logic [12:0] decode_mv(input logic [1:0] rng, input logic [7:0] c);
      case (rng)
         2'h0: decode_mv = (c >= pmic_regs_pkg::SAT_CODE_LOW_MID) ? 13'd1200 :
                           13'd500 + 13'(c) * 13'd5;
         2'h1: decode_mv = (c >= pmic_regs_pkg::SAT_CODE_LOW_MID) ? 13'd2400 :
                           13'd1000 + 13'(c) * 13'd10;
         2'h2: decode_mv = (c >= pmic_regs_pkg::SAT_CODE_HIGH) ? 13'd5200 :
                           13'd2000 + 13'(c) * 13'd20;
         default: decode_mv = 13'h0000;
      endcase
   endfunction : decode_mv

   // ---------------- Link domain: request capture ----------------
   logic req_tgl_reg;
   logic ack_seen_reg;
   logic ack_tgl_s;
   logic hold_write_reg;
   logic [7:0] hold_addr_reg;
   logic [7:0] hold_wdata_reg;
   logic [7:0] rd_data_reg;
   logic ack_tgl_reg;

   level_sync #(.WIDTH(1)) u_ack_sync (
      .clk(link_clk),
      .rst_b(rst_b),
      .d(ack_tgl_reg),
      .q(ack_tgl_s)
   );

   // Hold fields stay still until the answer returns, so the core may read them
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_tgl_reg <= 1'b0;
         acc_busy <= 1'b0;
         hold_write_reg <= 1'b0;
         hold_addr_reg <= 8'h00;
         hold_wdata_reg <= 8'h00;
      end else if (acc_valid && !acc_busy) begin
         req_tgl_reg <= ~req_tgl_reg;
         acc_busy <= 1'b1;
         hold_write_reg <= acc_write;
         hold_addr_reg <= acc_addr;
         hold_wdata_reg <= acc_wdata;
      end else if (ack_tgl_s != ack_seen_reg) begin
         acc_busy <= 1'b0;
      end
   end

   // Answer: read data is stable in the core before the ack toggle is seen
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_seen_reg <= 1'b0;
         acc_done <= 1'b0;
         acc_rdata <= 8'h00;
      end else begin
         ack_seen_reg <= ack_tgl_s;
         acc_done <= (ack_tgl_s != ack_seen_reg);
         if (ack_tgl_s != ack_seen_reg) begin
            acc_rdata <= rd_data_reg;
         end
      end
   end

   // ---------------- Core domain ----------------
   logic req_tgl_s;
   logic req_seen_reg;
   logic do_acc;
   logic do_wr;
   logic do_rd;
   logic [21:0] pins_s;
   logic uv_s;
   logic t165_s;
   logic t140_s;
   logic t120_s;
   logic ext_s;
   logic alt_s;
   logic [1:0] below_s;
   logic [1:0] above_s;
   logic [1:0] enpin_s;

   level_sync #(.WIDTH(1)) u_req_sync (
      .clk(mclk),
      .rst_b(rst_b),
      .d(req_tgl_reg),
      .q(req_tgl_s)
   );

   level_sync #(.WIDTH(22)) u_pin_sync (
      .clk(mclk),
      .rst_b(rst_b),
      .d({select_pin2, select_pin1, output_enable_pin, output_above_power_good,
          output_below_short, alternate_bias_input_good, external_reference_valid,
          temp_above_120, temp_above_140, temp_above_165, main_supply_input_low}),
      .q(pins_s)
   );

   assign uv_s = pins_s[0];
   assign t165_s = pins_s[1];
   assign t140_s = pins_s[2];
   assign t120_s = pins_s[3];
   assign ext_s = pins_s[4];
   assign alt_s = pins_s[5];
   assign below_s = pins_s[7:6];
   assign above_s = pins_s[9:8];
   assign enpin_s = pins_s[11:10];
   assign do_acc = (req_tgl_s != req_seen_reg);
   assign do_wr = do_acc && hold_write_reg;
   assign do_rd = do_acc && !hold_write_reg;

   // Request edge detect on the synchronised toggle
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         req_seen_reg <= 1'b0;
         ack_tgl_reg <= 1'b0;
      end else begin
         req_seen_reg <= req_tgl_s;
         if (do_acc) begin
            ack_tgl_reg <= ~ack_tgl_reg;
         end
      end
   end

   // Straps are caught once after the synchronisers have settled
   logic [1:0] strap_cnt_reg;
   logic [4:0] sel1_reg;
   logic [4:0] sel2_reg;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         strap_cnt_reg <= 2'h0;
         sel1_reg <= 5'h00;
         sel2_reg <= 5'h00;
      end else if (strap_cnt_reg != 2'(pmic_regs_pkg::STRAP_SETTLE_CYC)) begin
         strap_cnt_reg <= strap_cnt_reg + 2'h1;
         sel1_reg <= pins_s[16:12];
         sel2_reg <= pins_s[21:17];
      end
   end

   // Writable configuration
   logic [5:0] top_mask_reg;
   logic [3:0] out_mask_reg;
   logic bias_dis_reg;
   logic ftmon_reg;
   logic [1:0] power_good_timeout_sel_reg;
   logic [1:0] en_bit_reg;
   logic [1:0] lpm_reg;
   logic [7:0] vcode_reg;
   logic [7:0] range_cfg_reg;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         top_mask_reg <= pmic_regs_pkg::TOP_MASK_RST;
         out_mask_reg <= pmic_regs_pkg::OUT_MASK_RST;
         bias_dis_reg <= 1'b0;
         ftmon_reg <= 1'b0;
         power_good_timeout_sel_reg <= 2'h0;
         en_bit_reg <= 2'h0;
         lpm_reg <= 2'h0;
         soft_stop_ramp_code <= pmic_regs_pkg::SOFT_STOP_RST;
         soft_start_ramp_code <= pmic_regs_pkg::SOFT_START_RST;
         vcode_reg <= pmic_regs_pkg::VOLTAGE_CODE_RST;
         range_cfg_reg <= pmic_regs_pkg::RANGE_CONFIG_RST;
      end else if (do_wr) begin
         if (addr_hit(hold_addr_reg, pmic_regs_pkg::OFF_TOP_EVENT_MASK)) begin
            top_mask_reg <= hold_wdata_reg[5:0];
         end
         if (addr_hit(hold_addr_reg, pmic_regs_pkg::OFF_OUTPUT_EVENT_MASK)) begin
            out_mask_reg <= {hold_wdata_reg[5:4], hold_wdata_reg[1:0]};
         end
         if (addr_hit(hold_addr_reg, pmic_regs_pkg::OFF_BIAS_INPUT_CONFIG)) begin
            bias_dis_reg <= hold_wdata_reg[0];
         end
         if (addr_hit(hold_addr_reg, pmic_regs_pkg::OFF_PROTECTION_CONFIG)) begin
            ftmon_reg <= hold_wdata_reg[2];
            power_good_timeout_sel_reg <= hold_wdata_reg[1:0];
         end
         if (addr_hit(hold_addr_reg, pmic_regs_pkg::OFF_OUTPUT_ENABLE_CONTROL)) begin
            lpm_reg <= hold_wdata_reg[5:4];
            en_bit_reg <= hold_wdata_reg[1:0];
         end
         if (addr_hit(hold_addr_reg, pmic_regs_pkg::OFF_GLOBAL_RAMP_CONFIG)) begin
            soft_stop_ramp_code <= hold_wdata_reg[5:3];
            soft_start_ramp_code <= hold_wdata_reg[2:0];
         end
         if (addr_hit(hold_addr_reg, pmic_regs_pkg::OFF_OUTPUT1_VOLTAGE_CODE)) begin
            vcode_reg <= hold_wdata_reg;
         end
         if (addr_hit(hold_addr_reg, pmic_regs_pkg::OFF_OUTPUT1_RANGE_CONFIG)) begin
            range_cfg_reg <= hold_wdata_reg;
         end
      end
   end

   // Output enables: register bit or pin, dropped by fault or thermal shutdown
   logic [1:0] en_req;
   logic [1:0] shut_reg;
   assign en_req = en_bit_reg | enpin_s;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         output_enable <= 2'h0;
      end else begin
         output_enable <= en_req & ~shut_reg & {2{~t165_s}};
      end
   end

   // Power-good time-out: a low output for too long latches a shutdown
   // The latch only clears when the enable request is taken away
   logic [CNT_W-1:0] to_limit;
   always_comb begin
      case (power_good_timeout_sel_reg)
         2'h1: to_limit = CNT_W'(POK_TO1_CYC);
         2'h2: to_limit = CNT_W'(POK_TO2_CYC);
         2'h3: to_limit = CNT_W'(POK_TO3_CYC);
         default: to_limit = '0;
      endcase
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_power_good_timeout_sel
         logic [CNT_W-1:0] cnt_reg;
         logic latch_reg;
         // Each output owns its latch, so no vector has two processes behind it
         assign shut_reg[gi] = latch_reg;
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               cnt_reg <= '0;
               latch_reg <= 1'b0;
            end else if (!en_req[gi]) begin
               cnt_reg <= '0;
               latch_reg <= 1'b0;
            end else if (!output_enable[gi] || above_s[gi] || power_good_timeout_sel_reg == 2'h0) begin
               cnt_reg <= '0; // Code 0 disables the time-out
            end else if (cnt_reg >= to_limit - CNT_W'(1)) begin
               latch_reg <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + CNT_W'(1);
            end
         end
      end
   endgenerate

   // Live status, registered so event edges compare two stable samples
   logic [1:0] sc_stat_reg;
   logic [1:0] pg_stat_reg;
   logic [1:0] sc_next;
   logic [1:0] pg_next;
   logic swo_next;
   assign sc_next = below_s & output_enable;
   assign pg_next = above_s & output_enable;
   assign swo_next = alt_s & ~bias_dis_reg;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sc_stat_reg <= 2'h0;
         pg_stat_reg <= 2'h0;
         bias_from_alternate <= 1'b0;
      end else begin
         sc_stat_reg <= sc_next;
         pg_stat_reg <= pg_next;
         bias_from_alternate <= swo_next;
      end
   end

   // Previous comparator levels for rising-edge events
   logic uv_d_reg;
   logic t165_d_reg;
   logic t140_d_reg;
   logic t120_d_reg;
   logic ext_d_reg;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         uv_d_reg <= 1'b0;
         t165_d_reg <= 1'b0;
         t140_d_reg <= 1'b0;
         t120_d_reg <= 1'b0;
         ext_d_reg <= 1'b0;
      end else begin
         uv_d_reg <= uv_s;
         t165_d_reg <= t165_s;
         t140_d_reg <= t140_s;
         t120_d_reg <= t120_s;
         ext_d_reg <= ext_s;
      end
   end

   // Sticky top-level events; a new event in the clearing cycle survives
   logic [5:0] top_flags_reg;
   logic [5:0] top_set;
   logic top_clr;
   assign top_set[pmic_regs_pkg::BIT_UNDERVOLTAGE] = uv_s & ~uv_d_reg;
   assign top_set[pmic_regs_pkg::BIT_THERMAL_SHUTDOWN] = t165_s & ~t165_d_reg;
   assign top_set[pmic_regs_pkg::BIT_WARN_HIGH] = t140_s & ~t140_d_reg;
   assign top_set[pmic_regs_pkg::BIT_WARN_LOW] = t120_s & ~t120_d_reg;
   assign top_set[pmic_regs_pkg::BIT_EXT_REF] = ext_s & ~ext_d_reg;
   assign top_set[pmic_regs_pkg::BIT_BIAS_SWO] = swo_next & ~bias_from_alternate;
   assign top_clr = do_rd && addr_hit(hold_addr_reg, pmic_regs_pkg::OFF_TOP_EVENT_FLAGS);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         top_flags_reg <= 6'h00;
      end else begin
         top_flags_reg <= (top_flags_reg & {6{~top_clr}}) | top_set;
      end
   end

   // Sticky per-output events: short on entry, power-good on loss
   logic [3:0] out_flags_reg;
   logic [3:0] out_set;
   logic out_clr;
   assign out_set[3:2] = sc_next & ~sc_stat_reg;
   assign out_set[1:0] = pg_stat_reg & ~pg_next;
   assign out_clr = do_rd && addr_hit(hold_addr_reg, pmic_regs_pkg::OFF_OUTPUT_EVENT_FLAGS);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         out_flags_reg <= 4'h0;
      end else begin
         out_flags_reg <= (out_flags_reg & {4{~out_clr}}) | out_set;
      end
   end

   // Interrupt request and decoded target voltage
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_req <= 1'b0;
         output1_target_mv <= pmic_regs_pkg::TARGET_MV_RST;
      end else begin
         irq_req <= (|(top_flags_reg & ~top_mask_reg)) ||
                    (|(out_flags_reg & ~out_mask_reg));
         output1_target_mv <= decode_mv(range_cfg_reg[7:6], vcode_reg);
      end
   end

   // Read data captured in the access cycle; unmapped offsets read zero
   logic [7:0] rd_mux;
   always_comb begin
      case (hold_addr_reg)
         pmic_regs_pkg::OFF_TOP_EVENT_FLAGS: rd_mux = {2'b00, top_flags_reg};
         pmic_regs_pkg::OFF_TOP_EVENT_MASK: rd_mux = {2'b11, top_mask_reg};
         pmic_regs_pkg::OFF_TOP_LIVE_STATUS: rd_mux = {2'b00, ext_s, bias_from_alternate,
            uv_s, t165_s, t140_s, t120_s};
         pmic_regs_pkg::OFF_SEL_PIN1_CODE: rd_mux = {3'b000, sel1_reg};
         pmic_regs_pkg::OFF_SEL_PIN2_CODE: rd_mux = {3'b000, sel2_reg};
         pmic_regs_pkg::OFF_BIAS_INPUT_CONFIG: rd_mux = {7'h00, bias_dis_reg};
         pmic_regs_pkg::OFF_PROTECTION_CONFIG: rd_mux = {5'h00, ftmon_reg, power_good_timeout_sel_reg};
         pmic_regs_pkg::OFF_OUTPUT_ENABLE_CONTROL: rd_mux = {2'b00, lpm_reg, 2'b00, en_bit_reg};
         pmic_regs_pkg::OFF_GLOBAL_RAMP_CONFIG: rd_mux = {2'b00, soft_stop_ramp_code,
                                                          soft_start_ramp_code};
         pmic_regs_pkg::OFF_OUTPUT_EVENT_FLAGS: rd_mux = {2'b00, out_flags_reg[3:2], 2'b00,
                                                          out_flags_reg[1:0]};
         pmic_regs_pkg::OFF_OUTPUT_EVENT_MASK: rd_mux = {2'b11, out_mask_reg[3:2], 2'b11,
                                                         out_mask_reg[1:0]};
         pmic_regs_pkg::OFF_OUTPUT_LIVE_STATUS: rd_mux = {2'b00, sc_stat_reg, 2'b00,
                                                          pg_stat_reg};
         pmic_regs_pkg::OFF_OUTPUT1_VOLTAGE_CODE: rd_mux = vcode_reg;
         pmic_regs_pkg::OFF_OUTPUT1_RANGE_CONFIG: rd_mux = range_cfg_reg;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_reg <= 8'h00;
      end else if (do_acc) begin
         rd_data_reg <= rd_mux;
      end
   end

   // ---------------- Assertions ----------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   a_uv_event_set: assert property (uv_s && !uv_d_reg |=> top_flags_reg[3])
      else $error("undervoltage event not flagged");
   a_tsd_warn_set: assert property ($rose(t140_s) |-> ##1 top_flags_reg[1])
      else $error("high thermal warning not flagged");
   a_flags_read_clear: assert property (top_clr && top_set == 6'h00
      |=> top_flags_reg == 6'h00)
      else $error("top events not cleared by read");
   a_tsd_outputs_off: assert property (t165_s |=> output_enable == 2'h0)
      else $error("outputs stay on in thermal shutdown");
   a_pg_fall_event: assert property ($fell(pg_stat_reg[0]) |-> out_flags_reg[0])
      else $error("power-good loss not flagged");
   a_short_gated_off: assert property (output_enable[1] == 1'b0 |=> !sc_stat_reg[1])
      else $error("short status shown on disabled output");
   a_irq_follows: assert property ((top_flags_reg[3] && !top_mask_reg[3]) |=> irq_req)
      else $error("interrupt request missing");
   a_low_range_sat: assert property (range_cfg_reg[7:6] == 2'h0 && vcode_reg >= 8'h8c
      ##1 $stable(range_cfg_reg) && $stable(vcode_reg) |-> output1_target_mv == 13'd1200)
      else $error("low range does not saturate");
   a_shut_release: assert property (!en_req[0] |=> !shut_reg[0] && !output_enable[0])
      else $error("time-out latch not released");
   a_link_answer: assert property (@(posedge link_clk) disable iff (!rst_b)
      acc_valid && !acc_busy |-> ##[3:30] acc_done)
      else $error("register access never answered");

   c_top_read_clear: cover property (top_clr && top_flags_reg != 6'h00);
   c_pg_loss: cover property ($fell(pg_stat_reg[1]));
   c_timeout_shut: cover property ($rose(shut_reg[0]));
   c_irq_raise: cover property ($rose(irq_req));
endmodule : pmic_regs

// File: verification/host_model.sv
// Host model issuing single-byte accesses on the register port
module host_model (
   // Clock and answer
   input wire logic link_clk,
   input wire logic acc_done,
   input wire logic [7:0] acc_rdata,
   // Request
   output logic acc_valid,
   output logic acc_write,
   output logic [7:0] acc_addr,
   output logic [7:0] acc_wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle request lines at time zero
   initial begin
      acc_valid = 1'b0;
      acc_write = 1'b0;
      acc_addr = 8'h00;
      acc_wdata = 8'h00;
   end
   // One-cycle request, then a bounded wait for the answer
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] r);
      @(posedge link_clk);
      acc_valid <= 1'b1;
      acc_write <= w;
      acc_addr <= a;
      acc_wdata <= d;
      @(posedge link_clk);
      acc_valid <= 1'b0;
      acc_addr <= ~a; // Inverted so a stale address cannot pass
      acc_wdata <= ~d;
      for (int n = 0; n < 40 && acc_done !== 1'b1; n++)
         @(posedge link_clk);
      r = (acc_done === 1'b1) ? acc_rdata : 8'hxx; // Unknown marks a missing answer
   endtask : xfer
endmodule : host_model

// File: verification/testbench.sv
// Self-checking bench for the regulator register bank
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_b = 1'b0;
   logic acc_valid, acc_write, acc_done, busy, bias, irq, uv = 1'b0, ext = 1'b0, alt = 1'b0;
   logic [7:0] acc_addr, acc_wdata, acc_rdata, rd, v;
   logic [2:0] tj = 3'h0;
   logic [1:0] sc = 2'h0, pg = 2'h0, pin = 2'h0, en;
   logic [4:0] s1, s2;
   logic [2:0] ss, sp;
   logic [12:0] mv;
   int miscompares = 0;
   int checks = 0;
   // Core clock, and a link clock of unrelated phase
   always #10 mclk = ~mclk;
   initial #3 forever #7.5 link_clk = ~link_clk;
   pmic_regs #(.POK_TO1_CYC(20), .POK_TO2_CYC(40), .POK_TO3_CYC(80)) uut (
      .mclk, .rst_b, .link_clk, .acc_valid, .acc_write, .acc_addr, .acc_wdata,
      .acc_busy(busy), .acc_done, .acc_rdata, .main_supply_input_low(uv),
      .temp_above_165(tj[2]), .temp_above_140(tj[1]), .temp_above_120(tj[0]),
      .external_reference_valid(ext), .alternate_bias_input_good(alt),
      .output_below_short(sc), .output_above_power_good(pg), .output_enable_pin(pin),
      .select_pin1(s1), .select_pin2(s2), .output_enable(en), .bias_from_alternate(bias),
      .soft_start_ramp_code(ss), .soft_stop_ramp_code(sp), .output1_target_mv(mv),
      .irq_req(irq));
   host_model host (.link_clk, .acc_done, .acc_rdata, .acc_valid, .acc_write, .acc_addr,
      .acc_wdata);
   task automatic cmp(input logic [12:0] g, e);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task automatic rdc(input logic [7:0] a, e);
      host.xfer(1'b0, a, 8'h00, rd);
      cmp(13'(rd), 13'(e));
   endtask : rdc
   task automatic wr(input logic [7:0] a, d);
      host.xfer(1'b1, a, d, rd);
      cmp(13'($isunknown(rd)), 13'h0);
      repeat (4) @(posedge mclk);
   endtask : wr
   task automatic idle();
      repeat (8) @(posedge mclk);
   endtask : idle
   // Millivolts of a code in a range, saturating at the top code
   function automatic logic [12:0] vexp(int r, int c);
      int s;
      s = (r == 2) ? 160 : 140;
      return (r == 3) ? 13'h0000 : 13'((500 << r) + (5 << r) * ((c < s) ? c : s));
   endfunction : vexp
   task automatic results();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results
   // Watchdog far beyond the expected run length
   initial begin
      #300000;
      miscompares++;
      results();
   end
   // Main sequence
   initial begin
      void'($urandom(63196));
      s1 = 5'($urandom);
      s2 = 5'($urandom);
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      rdc(8'h03, 8'hf7);
      rdc(8'h21, 8'hff);
      rdc(8'h11, 8'h04);
      rdc(8'h23, 8'h41);
      rdc(8'h0b, 8'h00);
      rdc(8'h06, {3'h0, s1});
      rdc(8'h07, {3'h0, s2});
      // Busy must stand while the access is in flight and drop with the answer
      fork
         rdc(8'h05, 8'h00);
         begin
            repeat (3) @(posedge link_clk);
            cmp(13'(busy), 13'h1);
         end
      join
      cmp(13'(busy), 13'h0);
      cmp(mv, vexp(2, 8'h41));
      $display("reset test done");
      for (int r = 0; r < 4; r++) begin
         v = 8'($urandom);
         wr(8'h11, v);
         wr(8'h25, {2'(r), 6'h04});
         wr(8'h23, v);
         rdc(8'h11, {2'h0, v[5:0]});
         cmp(13'({sp, ss}), 13'(v[5:0]));
         cmp(mv, vexp(r, v));
         wr(8'h23, 8'h8c + 8'(10 * r));
         cmp(mv, vexp(r, 8'h8c + 10 * r));
      end
      $display("ramp and voltage test done");
      uv <= 1'b1;
      idle();
      cmp(13'(irq), 13'h1);
      rdc(8'h04, 8'h08);
      rdc(8'h02, 8'h08);
      rdc(8'h02, 8'h00);
      cmp(13'(irq), 13'h0);
      tj <= 3'h7;
      ext <= 1'b1;
      alt <= 1'b1;
      idle();
      cmp(13'(bias), 13'h1);
      rdc(8'h04, 8'h3f);
      rdc(8'h02, 8'h37);
      cmp(13'(irq), 13'h0);
      wr(8'h08, 8'h01);
      cmp(13'(bias), 13'h0);
      {uv, tj} <= 4'h0;
      idle();
      wr(8'h03, 8'h3e);
      tj <= 3'h1;
      idle();
      cmp(13'(irq), 13'h1);
      rdc(8'h04, 8'h21);
      $display("top event test done");
      wr(8'h0b, 8'h01);
      pin <= 2'h2;
      pg <= 2'h1;
      sc <= 2'h2;
      idle();
      cmp(13'(en), 13'h3);
      rdc(8'h22, 8'h21);
      pg <= 2'h0;
      idle();
      rdc(8'h20, 8'h21);
      pin <= 2'h0;
      wr(8'h09, 8'h01);
      repeat (60) @(posedge mclk);
      cmp(13'(en), 13'h0);
      rdc(8'h22, 8'h00);
      $display("output test done");
      results();
   end
endmodule : testbench
